// >>> bench/nvsq_host_bench.sv
// Self-checking bench for the host controller against the memory model.
// Assumes the checker and model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module nvsq_host_bench;
  import nvsq_pkg::*;
  logic I_MCLK = 1'b0, I_RESET = 1'b1, I_REQ = 1'b0, I_POWER_UP = 1'b0;
  logic [2:0] I_OP = OP_READ;
  logic [ADDR_W-1:0] I_ADDR = '0, O_ADDR;
  logic [DATA_W-1:0] I_WDATA = '0, O_RDATA, O_DQ, I_DQ;
  logic O_READY, O_DONE, O_AUTO_ON_SENT, O_SAVE_PENDING, O_CE_N, O_OE_N, O_WE_N;
  logic O_UPPER_BYTE_EN_N, O_LOWER_BYTE_EN_N, O_DQ_OE_N, I_STORE_BUSY_N;
  logic O_STORE_BUSY_N, O_STORE_BUSY_OE_N, busy_low;
  int errors = 0, samples_checked = 0;
  // Open-drain busy line with pull-up: low if either side pulls it.
  assign I_STORE_BUSY_N = !busy_low && (O_STORE_BUSY_OE_N || O_STORE_BUSY_N);
  always #5 I_MCLK = ~I_MCLK;
  nvsq_host #(.RD_CYC(2), .GAP_CYC(2)) uut (.*);
  nvsq_mem_model mdl (.i_clk(I_MCLK), .i_addr(O_ADDR), .i_ce_n(O_CE_N), .i_oe_n(O_OE_N),
    .i_we_n(O_WE_N), .i_dq(O_DQ), .i_dq_oe_n(O_DQ_OE_N), .o_dq(I_DQ), .o_busy_low(busy_low));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic run(input logic [2:0] o, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    I_REQ = 1'b1;
    I_OP = o;
    I_ADDR = a;
    I_WDATA = d;
    @(posedge I_MCLK);
    #1 I_REQ = 1'b0;
    for (n = 0; n < 2000 && O_DONE !== 1'b1; n++) begin
      @(posedge I_MCLK);
      #1;
    end
    check(O_DONE, 1'b1, "done");
  endtask
  task automatic t_reset();
    check(O_READY, 1'b1, "ready");
    check(O_AUTO_ON_SENT, 1'b0, "sent");
    check(mdl.auto, 1'b1, "auto");
    check(mdl.nv[8'h55], 8'h00, "nv");
    check(O_UPPER_BYTE_EN_N, 1'b0, "upper_en");
    check(O_LOWER_BYTE_EN_N, 1'b0, "lower_en");
    check(O_STORE_BUSY_N, 1'b1, "busy_out");
    $display("t_reset done");
  endtask
  task automatic t_rw();
    run(OP_WRITE, 19'h0_0055, 8'hA5);
    run(OP_READ, 19'h0_0055, 8'h00);
    check(O_RDATA, 8'hA5, "rdata");
    $display("t_rw done");
  endtask
  task automatic t_store_recall();
    run(OP_AUTO_OFF, '0, 8'h00);
    check(mdl.auto, 1'b0, "auto");
    check(O_SAVE_PENDING, 1'b1, "pending");
    run(OP_STORE, '0, 8'h00);
    check(mdl.nv[8'h55], 8'hA5, "nv");
    check(I_STORE_BUSY_N, 1'b1, "busy");
    check(O_SAVE_PENDING, 1'b0, "pending");
    run(OP_WRITE, 19'h0_0055, 8'h3C);
    run(OP_AUTO_ON, '0, 8'h00);
    run(OP_RECALL, '0, 8'h00);
    run(OP_READ, 19'h0_0055, 8'h00);
    check(O_RDATA, 8'hA5, "recall");
    check(mdl.auto, 1'b0, "auto");
    $display("t_store_recall done");
  endtask
  task automatic t_auto_on();
    run(OP_AUTO_ON, '0, 8'h00);
    check(mdl.auto, 1'b1, "auto");
    check(O_AUTO_ON_SENT, 1'b1, "sent");
    I_POWER_UP = 1'b1;
    @(posedge I_MCLK);
    #1 I_POWER_UP = 1'b0;
    @(posedge I_MCLK);
    #1;
    check(O_AUTO_ON_SENT, 1'b0, "sent");
    $display("t_auto_on done");
  endtask
  task automatic t_protect();
    mdl.low_supply = 1'b1;
    run(OP_WRITE, 19'h0_0055, 8'h77);
    run(OP_STORE, '0, 8'h00);
    mdl.low_supply = 1'b0;
    check(mdl.stores, 32'd1, "stores");
    run(OP_READ, 19'h0_0055, 8'h00);
    check(O_RDATA, 8'hA5, "rdata");
    mdl.power_cycle();
    check(mdl.stores, 32'd1, "stores");
    check(mdl.auto, 1'b0, "auto");
    run(OP_AUTO_ON, '0, 8'h00);
    run(OP_WRITE, 19'h0_0055, 8'h5A);
    mdl.power_cycle();
    check(mdl.stores, 32'd2, "stores");
    check(mdl.nv[8'h55], 8'h5A, "nv");
    check(mdl.auto, 1'b1, "auto");
    $display("t_protect done");
  endtask
  initial begin
    repeat (20) @(posedge I_MCLK);
    #1 I_RESET = 1'b0;
    t_reset();
    t_rw();
    t_store_recall();
    t_auto_on();
    t_protect();
    summarize();
  end
  // About 350 cycles are expected; the 20000-cycle limit means a hang.
  initial begin
    #200000;
    errors++;
    summarize();
  end
endmodule // nvsq_host_bench
bind nvsq_host nvsq_host_checker #(.RD_CYC(RD_CYC)) chk (.*);
`default_nettype wire

// >>> bench/nvsq_host_checker.sv
// Pin-level assertions on the host controller.
// Assumes it is bound into nvsq_host with the same RD_CYC.
`timescale 1ns/1ps
`default_nettype none
module nvsq_host_checker
  import nvsq_pkg::*;
#(
  parameter int RD_CYC = READ_CYCLES
) (
  input wire logic              I_MCLK,
  input wire logic              I_RESET,
  input wire logic              I_REQ,
  input wire logic [2:0]        I_OP,
  input wire logic              I_STORE_BUSY_N,
  input wire logic              O_READY,
  input wire logic              O_DONE,
  input wire logic [ADDR_W-1:0] O_ADDR,
  input wire logic              O_CE_N,
  input wire logic              O_OE_N,
  input wire logic              O_WE_N,
  input wire logic              O_STORE_BUSY_OE_N
);
  logic [2:0]       op_reg;
  logic [CNT_W-1:0] low_reg;
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      op_reg  <= OP_READ;
      low_reg <= '0;
    end else begin
      if (O_READY && I_REQ) op_reg <= I_OP;
      low_reg <= O_CE_N ? '0 : low_reg + 1'b1;
    end
  end
  idle_strobes_a: assert property (O_READY |-> O_CE_N && O_WE_N && O_OE_N)
    else $error("Strobe active while idle");
  seq_no_write_a: assert property (!O_READY && op_reg < OP_READ |-> O_WE_N)
    else $error("Write strobe low in a mode sequence");
  one_strobe_a: assert property ($fell(O_CE_N) |-> O_OE_N != O_WE_N)
    else $error("Access starts without exactly one strobe");
  addr_hold_a: assert property (!O_CE_N && !$past(O_CE_N) |-> $stable(O_ADDR))
    else $error("Address moved during an access");
  read_len_a: assert property ($rose(O_CE_N) |-> low_reg == RD_CYC)
    else $error("Chip select low for wrong cycle count");
  done_idle_a: assert property (O_DONE |-> (O_CE_N && O_WE_N) ##[0:1] O_READY)
    else $error("Done without idle strobes");
  busy_wait_a: assert property (!I_STORE_BUSY_N [*4] |-> O_CE_N)
    else $error("Access started while memory busy");
  busy_float_a: assert property (O_STORE_BUSY_OE_N)
    else $error("Host drove the busy line");
endmodule // nvsq_host_checker
`default_nettype wire

// >>> bench/nvsq_mem_model.sv
// Behavioural model of the nonvolatile memory behind the host.
// Assumes host strobes change just after the clock edge it receives.
`timescale 1ns/1ps
`default_nettype none
module nvsq_mem_model
  import nvsq_pkg::*;
#(
  parameter int STORE_CYC = 40
) (
  input  wire logic              i_clk,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_ce_n,
  input  wire logic              i_oe_n,
  input  wire logic              i_we_n,
  input  wire logic [DATA_W-1:0] i_dq,
  input  wire logic              i_dq_oe_n,
  output logic      [DATA_W-1:0] o_dq,
  output logic                   o_busy_low
);
  localparam logic [15:0] KEYS [5] = '{KEY_1, KEY_2, KEY_3, KEY_4, KEY_5};
  logic [DATA_W-1:0] mem [256];
  logic [DATA_W-1:0] nv [256];
  logic [DATA_W-1:0] last = '0;
  logic [ADDR_W-1:0] la = '0;
  logic [2:0]        step = '0;
  logic              ce_q = 1'b1, lwr = 1'b0, auto = 1'b1, nv_auto = 1'b1;
  int                bcnt = 0;
  logic              low_supply = 1'b0, dirty = 1'b0, wr_hold = 1'b0;
  int                stores = 0;
  function automatic logic hit(input logic [15:0] k);
    return la[KEY_MSB:KEY_LSB] == k[KEY_MSB:KEY_LSB];
  endfunction
  // Power loss and return: an unwritten array is not saved, then it reloads.
  task automatic power_cycle();
    if (auto && dirty) begin
      nv = mem;
      nv_auto = auto;
      stores++;
    end
    mem = nv;
    auto = nv_auto;
    dirty = 1'b0;
  endtask
  initial foreach (nv[i]) begin
    nv[i] = 8'h00;
    mem[i] = 8'h00;
  end
  assign o_busy_low = bcnt != 0;
  // Released data shows the inverse so a stale value never passes as a read.
  assign o_dq = (!i_ce_n && !i_oe_n && i_we_n && bcnt == 0) ? mem[i_addr[7:0]] : ~last;
  always @(posedge i_clk) begin
    ce_q <= i_ce_n;
    if (bcnt != 0) bcnt <= bcnt - 1;
    if (bcnt == 1 && !i_ce_n && !i_we_n) wr_hold <= 1'b1;
    else if (i_ce_n) wr_hold <= 1'b0;
    if (!i_ce_n) begin
      la <= i_addr;
      lwr <= !i_we_n;
      // Writes are dropped under low supply, while busy and when held over busy.
      if (!i_we_n && !i_dq_oe_n && !low_supply && bcnt == 0 && !wr_hold) begin
        mem[i_addr[7:0]] <= i_dq;
        dirty <= 1'b1;
      end
      if (!i_oe_n && i_we_n) last <= o_dq;
    end
    if (i_ce_n && !ce_q) begin
      step <= hit(KEY_1) ? 3'h1 : 3'h0;
      if (lwr) step <= 3'h0;
      else if (step < 5 && hit(KEYS[step])) step <= step + 3'h1;
      else if (step == 5) begin
        if (hit(CMD_STORE) && !low_supply) begin
          nv <= mem;
          nv_auto <= auto;
          bcnt <= STORE_CYC;
          stores <= stores + 1;
          dirty <= 1'b0;
        end
        if (hit(CMD_RECALL)) begin
          mem <= nv;
          auto <= nv_auto;
          dirty <= 1'b0;
        end
        if (hit(CMD_AUTO_OFF)) auto <= 1'b0;
        if (hit(CMD_AUTO_ON)) auto <= 1'b1;
      end
    end
  end
endmodule // nvsq_mem_model
`default_nettype wire

// >>> rtl/nvsq_host.sv
// Host controller that issues single reads, writes and six-read mode
// sequences to an asynchronous nonvolatile static memory.
// Assumes the memory pins are wired directly; inputs from them are async.
`timescale 1ns/1ps
`default_nettype none
// Function
// [RL1] Device matches only address bits 14..2.
// [RL2] Sequence starts with three key reads.
// [RL3] Fourth and fifth keys precede command read.
// [RL4] Six consecutive reads, write strobe high.
// [RL5] Steps are chip-select controlled reads only.
// [RL6] Command 8B45 turns automatic save off.
// [RL7] Command 4B46 turns automatic save on.
// [RL8] Command 8FC0 starts store, outputs float.
// [RL9] Setting change must be followed by store.
// [RL10] Automatic save enabled as shipped.
// [RL11] Low supply blocks writes and stores.
// [RL12] Write held at busy release is suppressed.
// [RL13] Shipped nonvolatile cells hold zero.
// [RL14] Host re-applies settings at every power-up; this controller only clears O_AUTO_ON_SENT.
// [RL15] Command 4C63 starts a recall.
// [RL16] Intervening access aborts the sequence.
// [RL17] Busy pin low while store runs.
// [RL18] Unwritten auto/hardware stores are skipped.
// [RL19] Mismatch restarts decoder at first key.
// [RL20] Save flag latched, stored and recalled.
module nvsq_host
  import nvsq_pkg::*;
#(
  parameter int RD_CYC  = READ_CYCLES,
  parameter int GAP_CYC = GAP_CYCLES
) (
  input  wire logic              I_MCLK,
  input  wire logic              I_RESET,
  input  wire logic              I_REQ,
  input  wire logic [2:0]        I_OP,
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic [DATA_W-1:0] I_WDATA,
  input  wire logic              I_POWER_UP,
  output logic                   O_READY,
  output logic                   O_DONE,
  output logic [DATA_W-1:0]      O_RDATA,
  output logic                   O_AUTO_ON_SENT,
  output logic                   O_SAVE_PENDING,
  output logic [ADDR_W-1:0]      O_ADDR,
  output logic                   O_CE_N,
  output logic                   O_OE_N,
  output logic                   O_WE_N,
  output logic                   O_UPPER_BYTE_EN_N,
  output logic                   O_LOWER_BYTE_EN_N,
  output logic [DATA_W-1:0]      O_DQ,
  output logic                   O_DQ_OE_N,
  input  wire logic [DATA_W-1:0] I_DQ,
  input  wire logic              I_STORE_BUSY_N,
  output logic                   O_STORE_BUSY_N,
  output logic                   O_STORE_BUSY_OE_N
);
  initial begin
    if (RD_CYC < 2 || RD_CYC > 255 || GAP_CYC < 1 || GAP_CYC > 255) begin
      $error("nvsq_host: read count must lie in 2..255 and gap count in 1..255");
    end
  end

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b0_0001,
    ST_WAIT  = 5'b0_0010,
    ST_CYC   = 5'b0_0100,
    ST_GAP   = 5'b0_1000,
    ST_BUSY  = 5'b1_0000
  } nvsq_state_e;

  typedef struct packed {
    nvsq_state_e         st;
    logic [2:0]          op;
    logic [2:0]          step;
    logic [CNT_W-1:0]    cnt;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   rdata;
    logic                ce_n;
    logic                we_n;
    logic                oe_n;
    logic                done;
    logic                auto_on;
    logic                pending;
  } nvsq_state_s;

  nvsq_state_s      s_reg;
  nvsq_state_s      s_next;
  logic             busy_n_s;
  logic [DATA_W-1:0] dq_s;

  nvsq_sync #(.W(1)) u_busy_sync (
    .i_clk   (I_MCLK),
    .i_reset (I_RESET),
    .i_async (I_STORE_BUSY_N),
    .o_sync  (busy_n_s)
  );

  nvsq_sync #(.W(DATA_W)) u_dq_sync (
    .i_clk   (I_MCLK),
    .i_reset (I_RESET),
    .i_async (I_DQ),
    .o_sync  (dq_s)
  );

  function automatic logic [ADDR_W-1:0] key_addr(input logic [2:0] op, input logic [2:0] step);
    logic [15:0] k;
    k = KEY_1;
    case (step)
      3'd0: k = KEY_1;
      3'd1: k = KEY_2;
      3'd2: k = KEY_3;
      3'd3: k = KEY_4;
      3'd4: k = KEY_5;
      default: begin
        case (op)
          OP_STORE:    k = CMD_STORE;
          OP_RECALL:   k = CMD_RECALL;
          OP_AUTO_OFF: k = CMD_AUTO_OFF;
          default:     k = CMD_AUTO_ON;
        endcase
      end
    endcase
    // The device compares bits 14..2 only; bits 18..16 are driven zero.
    key_addr = {{(ADDR_W-16){1'b0}}, k}; // RL1
    return key_addr;
  endfunction

  wire is_seq = (s_reg.op <= OP_AUTO_ON);

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    if (I_POWER_UP) begin
      // A fresh power cycle may revert the setting; firmware re-applies it.
      s_next.auto_on = 1'b0; // RL14
    end
    case (s_reg.st)
      ST_IDLE: begin
        if (I_REQ) begin
          s_next.op    = I_OP;
          s_next.step  = 3'd0;
          s_next.wdata = I_WDATA;
          s_next.addr  = (I_OP <= OP_AUTO_ON) ? key_addr(I_OP, 3'd0) : I_ADDR; // RL2
          s_next.st    = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Device holds busy low while a store runs; wait for release.
        if (busy_n_s) begin // RL17
          s_next.ce_n = 1'b0;
          // Sequences use chip-select controlled reads, write strobe high.
          s_next.we_n = !(s_reg.op == OP_WRITE) ? 1'b1 : 1'b0; // RL4 RL5
          s_next.oe_n = (s_reg.op == OP_WRITE);
          s_next.cnt  = CNT_W'(RD_CYC);
          s_next.st   = ST_CYC;
        end
      end
      ST_CYC: begin
        if (s_reg.cnt == CNT_W'(1)) begin
          s_next.ce_n = 1'b1;
          s_next.we_n = 1'b1;
          s_next.oe_n = 1'b1;
          s_next.cnt = CNT_W'(GAP_CYC);
          s_next.st  = ST_GAP;
        end else begin
          s_next.cnt = s_reg.cnt - CNT_W'(1);
        end
      end
      ST_GAP: begin
        // Read data trails the pins by two flops, so it is taken on the
        // first gap cycle rather than at the last strobe cycle.
        if (s_reg.op == OP_READ && s_reg.cnt == CNT_W'(GAP_CYC)) begin
          s_next.rdata = dq_s;
        end
        if (s_reg.cnt == CNT_W'(1)) begin
          if (is_seq && s_reg.step != 3'd5) begin
            // Next key follows directly; nothing else may intervene.
            s_next.step = s_reg.step + 3'd1; // RL3 RL16
            s_next.addr = key_addr(s_reg.op, s_reg.step + 3'd1);
            s_next.st   = ST_WAIT;
          end else begin
            if (s_reg.op == OP_AUTO_OFF || s_reg.op == OP_AUTO_ON) begin
              s_next.auto_on = (s_reg.op == OP_AUTO_ON);
              s_next.pending = 1'b1; // RL9
            end
            if (s_reg.op == OP_STORE) begin
              s_next.pending = 1'b0; // RL9
            end
            s_next.st = (is_seq) ? ST_BUSY : ST_IDLE;
            s_next.cnt = CNT_W'(BUSY_CYCLES);
            s_next.done = !is_seq;
          end
        end else begin
          s_next.cnt = s_reg.cnt - CNT_W'(1);
        end
      end
      ST_BUSY: begin
        // Busy is pulled a cycle late and reaches us through two flops, so
        // it is ignored until the settle count has run down.
        if (s_reg.cnt != CNT_W'(1)) begin
          s_next.cnt = s_reg.cnt - CNT_W'(1);
        end else if (busy_n_s) begin // RL17
          s_next.done = 1'b1;
          s_next.st   = ST_IDLE;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      s_reg <= '{st: ST_IDLE, op: OP_READ, step: 3'd0, cnt: '0, addr: '0, wdata: '0,
                 rdata: '0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, done: 1'b0,
                 auto_on: 1'b0, pending: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign O_READY           = (s_reg.st == ST_IDLE);
  assign O_DONE            = s_reg.done;
  assign O_RDATA           = s_reg.rdata;
  assign O_AUTO_ON_SENT    = s_reg.auto_on;
  assign O_SAVE_PENDING    = s_reg.pending;
  assign O_ADDR            = s_reg.addr;
  assign O_CE_N            = s_reg.ce_n;
  assign O_OE_N            = s_reg.oe_n;
  assign O_WE_N            = s_reg.we_n;
  assign O_UPPER_BYTE_EN_N = 1'b0;
  assign O_LOWER_BYTE_EN_N = 1'b0;
  assign O_DQ              = s_reg.wdata;
  assign O_DQ_OE_N         = !(s_reg.op == OP_WRITE && !s_reg.we_n);
  // The host never requests hardware stores, so the busy pin stays released.
  assign O_STORE_BUSY_N    = 1'b1;
  assign O_STORE_BUSY_OE_N = 1'b1;
endmodule // nvsq_host
`default_nettype wire

// >>> rtl/nvsq_pkg.sv
// Package for the nonvolatile-memory mode sequence host controller.
// Assumes a single 100 MHz clock domain in the user of this package.
package nvsq_pkg;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          ADDR_W          = 19;
  localparam int          DATA_W          = 8;
  localparam int          KEY_LSB         = 2;
  localparam int          KEY_MSB         = 14;
  localparam logic [15:0] KEY_1           = 16'h4E38;
  localparam logic [15:0] KEY_2           = 16'hB1C7;
  localparam logic [15:0] KEY_3           = 16'h83E0;
  localparam logic [15:0] KEY_4           = 16'h7C1F;
  localparam logic [15:0] KEY_5           = 16'h703F;
  localparam logic [15:0] CMD_STORE       = 16'h8FC0;
  localparam logic [15:0] CMD_RECALL      = 16'h4C63;
  localparam logic [15:0] CMD_AUTO_OFF    = 16'h8B45;
  localparam logic [15:0] CMD_AUTO_ON     = 16'h4B46;
  localparam int          READ_CYCLE_NS   = 45;
  localparam int          READ_CYCLES     = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          GAP_NS          = 20;
  localparam int          GAP_CYCLES      = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          BUSY_CYCLES     = 4;
  localparam int          CNT_W           = 8;
  localparam logic [2:0]  OP_STORE        = 3'h0;
  localparam logic [2:0]  OP_RECALL       = 3'h1;
  localparam logic [2:0]  OP_AUTO_OFF     = 3'h2;
  localparam logic [2:0]  OP_AUTO_ON      = 3'h3;
  localparam logic [2:0]  OP_READ         = 3'h4;
  localparam logic [2:0]  OP_WRITE        = 3'h5;
endpackage : nvsq_pkg

// >>> rtl/nvsq_sync.sv
// Two-flop synchroniser for pin inputs of the host controller.
// Assumes the input is asynchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module nvsq_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule // nvsq_sync
`default_nettype wire
